// File: hw/pic_ctrl.sv
// Functional notes
// (R1) Nine sources: wakeup group, two pins, timers A-D, serial, A/D.
// (R2) Each source has flag, mask, vector; one global enable gates all.
// (R3) Timers B and D share a vector; serial and A/D share one.
// (R4) Software polls flags on shared vectors to find the source.
// (R5) Enable, flag and mask bits are bit-accessible in two small register groups.
// (R6) Software may clear request flags but never set them.
// (R7) Reset clears enable and flags, sets every mask.
// (R8) A source requests only when flag is one and mask zero.
// (R9) Handling starts only with a pending request and enable set.
// (R10) Priority encoder picks highest pending request and its vector.
// (R11) Wakeup 1 at 0002, pin 0 2 at 0004, pin 1 3 at 0006, reset 0000.
// (R12) Timer A 4 at 0008, timers B/D 5 at 000A, timer C 6 at 000C.
// (R13) Serial/A-D lowest priority 7 at 000E.
// (R14) First handling cycle completes the instruction in progress.
// (R15) Second cycle clears the global enable.
// (R16) Second and third cycles push carry, status and program counter.
// (R17) Third cycle loads the vector into the program counter.
// (R18) Software places a long jump at each vector.
// (R19) Service routine clears its own request flag.
// (R20) Interrupt return sets the global enable again.
// (R21) Interrupt return restores carry and status; plain return does not.
// (R22) Each save lowers the stack pointer by four, each restore raises it.
// (R23) Wakeup flag set on falling edge except when leaving stop mode.
// (R24) Flags set regardless of mask, so masked requests stay pending.
// (R25) Acceptance only at instruction boundaries.
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.svh"
module pic_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] wakeup_in_n,
  input wire logic ext_irq_input_0,
  input wire logic ext_irq_input_1,
  input wire logic [1:0] ext_irq_input_1_edge_sel,
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic timer_c_ovf,
  input wire logic timer_d_event,
  input wire logic serial_done,
  input wire logic adc_done,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic subroutine_return_instr,
  input wire logic carry_flag,
  input wire logic branch_status_flag,
  input wire logic [13:0] cpu_pc,
  output logic irq_take,
  output logic irq_hold_fetch,
  output logic stack_push,
  output logic [9:0] stack_addr,
  output logic [15:0] stack_wdata,
  output logic pc_load,
  output logic [13:0] pc_load_value,
  input wire logic [15:0] stack_rdata,
  output logic flags_restore,
  output logic carry_restore,
  output logic status_restore,
  output logic global_irq_enable
);
  pic_pkg::pic_state_type state_q;
  logic [8:0] flag_q;
  logic [8:0] irq_mask_bit;
  logic [9:0] sp_q;
  logic stop_q;
  logic [13:0] vec_q;
  logic [8:0] pending;
  logic [8:0] hw_set;
  logic [8:0] sw_clr;
  logic any_pending;
  logic [13:0] vector;
  logic wakeup_fall;
  logic ext_irq_input_0_fall;
  logic ext_irq_input_1_event;
  logic wr;
  logic rd;
  logic hit;
  logic accept;
  logic ret_irq;

  pic_edge u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .wakeup_in_n(wakeup_in_n),
    .ext_irq_input_0(ext_irq_input_0),
    .ext_irq_input_1(ext_irq_input_1),
    .ext_irq_input_1_edge_sel(ext_irq_input_1_edge_sel),
    .wakeup_fall(wakeup_fall),
    .ext_irq_input_0_fall(ext_irq_input_0_fall),
    .ext_irq_input_1_event(ext_irq_input_1_event)
  );

  assign pending = flag_q & ~irq_mask_bit; // R8
  pic_prio u_prio ( // R10
    .pending(pending),
    .any(any_pending),
    .vector(vector)
  );

  // Zero-wait slave: every access finishes in its first access cycle.
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  always_comb begin
    hit = 1'b1;
    if (paddr == `PIC_ADDR_IRQ) begin
    end else if (paddr == `PIC_ADDR_CTRL) begin
    end else if (paddr == `PIC_ADDR_MASK) begin
    end else if (paddr == `PIC_ADDR_FLAG) begin
    end else if (paddr == `PIC_ADDR_STAT) begin
    end else if (paddr == `PIC_ADDR_SP) begin
    end else if (paddr == `PIC_ADDR_PC) begin
    end else begin
      hit = 1'b0;
    end
  end
  assign pslverr = psel & penable & ~hit;

  // Stop-mode wakeups resume the part without posting a request.
  assign hw_set[`PIC_SRC_WU] = wakeup_fall & ~stop_q; // R23 R1
  assign hw_set[`PIC_SRC_EXT_IRQ_INPUT_0] = ext_irq_input_0_fall;
  assign hw_set[`PIC_SRC_EXT_IRQ_INPUT_1] = ext_irq_input_1_event;
  assign hw_set[`PIC_SRC_TA] = timer_a_ovf;
  assign hw_set[`PIC_SRC_TB] = timer_b_ovf;
  assign hw_set[`PIC_SRC_TD] = timer_d_event;
  assign hw_set[`PIC_SRC_TC] = timer_c_ovf;
  assign hw_set[`PIC_SRC_SER] = serial_done;
  assign hw_set[`PIC_SRC_AD] = adc_done;

  // Written ones in flag positions are ignored; a written zero clears.
  always_comb begin
    sw_clr = 9'h000;
    if (wr && paddr == `PIC_ADDR_FLAG) begin
      sw_clr = ~pwdata[8:0]; // R6 R5
    end else if (wr && paddr == `PIC_ADDR_IRQ) begin
      sw_clr[`PIC_SRC_WU] = ~pwdata[`PIC_IRQ_WUF_BIT]; // R6
    end
  end

  // Set wins over a clear in the same cycle so no event is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= `PIC_FLAG_RST; // R7
    end else begin
      flag_q <= (flag_q & ~sw_clr) | hw_set; // R24 R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_bit <= `PIC_MASK_RST; // R7
    end else if (wr && paddr == `PIC_ADDR_MASK) begin
      irq_mask_bit <= pwdata[8:0]; // R5
    end else if (wr && paddr == `PIC_ADDR_IRQ) begin
      irq_mask_bit[`PIC_SRC_WU] <= pwdata[`PIC_IRQ_WUM_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_q <= 1'b0;
    end else if (wr && paddr == `PIC_ADDR_CTRL) begin
      stop_q <= pwdata[`PIC_CTRL_STOP_BIT];
    end
  end

  assign ret_irq = return_from_irq_instr & (state_q == pic_pkg::PIC_IDLE);
  assign accept = (state_q == pic_pkg::PIC_IDLE) & instr_boundary & any_pending & global_irq_enable; // R9 R25

  // Hardware clear in cycle two beats a same-cycle software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0; // R7
    end else if (state_q == pic_pkg::PIC_CYC1) begin
      global_irq_enable <= 1'b0; // R15
    end else if (ret_irq) begin
      global_irq_enable <= 1'b1; // R20
    end else if (wr && paddr == `PIC_ADDR_IRQ) begin
      global_irq_enable <= pwdata[`PIC_IRQ_IE_BIT]; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pic_pkg::PIC_IDLE;
    end else begin
      case (state_q)
        pic_pkg::PIC_IDLE: begin
          if (accept) begin
            state_q <= pic_pkg::PIC_CYC1; // R14
          end
        end
        pic_pkg::PIC_CYC1: begin
          state_q <= pic_pkg::PIC_CYC2;
        end
        pic_pkg::PIC_CYC2: begin
          state_q <= pic_pkg::PIC_CYC3;
        end
        default: begin
          state_q <= pic_pkg::PIC_IDLE;
        end
      endcase
    end
  end

  // Vector is frozen at acceptance so a later request cannot retarget the jump.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= `PIC_PC_RST;
    end else if (accept) begin
      vec_q <= vector; // R11 R12 R13 R3
    end
  end

  // One push of carry, status and pc spans cycles two and three.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= `PIC_SP_RST;
    end else if (state_q == pic_pkg::PIC_CYC2) begin
      sp_q <= {`PIC_SP_TOP, 6'(sp_q - `PIC_SP_STEP)}; // R22
    end else if (return_from_irq_instr | subroutine_return_instr) begin
      sp_q <= {`PIC_SP_TOP, 6'(sp_q + `PIC_SP_STEP)}; // R22
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_wdata <= 16'h0000;
    end else if (state_q == pic_pkg::PIC_CYC1) begin
      stack_wdata <= {carry_flag, branch_status_flag, cpu_pc}; // R16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load_value <= `PIC_PC_RST;
    end else if (state_q == pic_pkg::PIC_CYC2) begin
      pc_load_value <= vec_q; // R17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_restore <= 1'b0;
      status_restore <= `PIC_ST_RST;
    end else if (return_from_irq_instr) begin
      carry_restore <= stack_rdata[15]; // R21
      status_restore <= stack_rdata[14];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_restore <= 1'b0;
    end else begin
      flags_restore <= return_from_irq_instr; // R21
    end
  end

  assign irq_take = accept;
  assign irq_hold_fetch = state_q != pic_pkg::PIC_IDLE;
  assign stack_push = (state_q == pic_pkg::PIC_CYC2) | (state_q == pic_pkg::PIC_CYC3); // R16
  assign stack_addr = sp_q;
  assign pc_load = state_q == pic_pkg::PIC_CYC3; // R17

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      if (paddr == `PIC_ADDR_IRQ) begin
        prdata <= {28'h0, irq_mask_bit[`PIC_SRC_WU], flag_q[`PIC_SRC_WU], 1'b0, global_irq_enable};
      end else if (paddr == `PIC_ADDR_CTRL) begin
        prdata <= {31'h0, stop_q};
      end else if (paddr == `PIC_ADDR_MASK) begin
        prdata <= {23'h0, irq_mask_bit};
      end else if (paddr == `PIC_ADDR_FLAG) begin
        prdata <= {23'h0, flag_q}; // R4
      end else if (paddr == `PIC_ADDR_STAT) begin
        prdata <= {23'h0, pending};
      end else if (paddr == `PIC_ADDR_SP) begin
        prdata <= {22'h0, sp_q};
      end else if (paddr == `PIC_ADDR_PC) begin
        prdata <= {18'h0, vec_q};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end
endmodule
`default_nettype wire

// File: hw/pic_edge.sv
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.svh"
module pic_edge (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] wakeup_in_n,
  input wire logic ext_irq_input_0,
  input wire logic ext_irq_input_1,
  input wire logic [1:0] ext_irq_input_1_edge_sel,
  output logic wakeup_fall,
  output logic ext_irq_input_0_fall,
  output logic ext_irq_input_1_event
);
  logic [3:0] wu_q;
  logic ext_irq_input_0_q;
  logic ext_irq_input_1_q;
  logic ext_irq_input_1_seen_q;
  logic [3:0] wu_fall;

  // Previous levels start high, so a wakeup or pin 0 input that is low at reset release counts as a falling edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wu_q <= 4'hF;
      ext_irq_input_0_q <= 1'b1;
      ext_irq_input_1_q <= 1'b1;
    end else begin
      wu_q <= wakeup_in_n;
      ext_irq_input_0_q <= ext_irq_input_0;
      ext_irq_input_1_q <= ext_irq_input_1;
    end
  end

  // The idle level of this pin is unknown, so no edge counts until one real sample is held.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_irq_input_1_seen_q <= 1'b0;
    end else begin
      ext_irq_input_1_seen_q <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_wu
      assign wu_fall[i] = wu_q[i] & ~wakeup_in_n[i];
    end
  endgenerate

  assign wakeup_fall = |wu_fall;
  assign ext_irq_input_0_fall = ext_irq_input_0_q & ~ext_irq_input_0;
  // Select 0 rising, 1 falling, otherwise both edges.
  always_comb begin
    case (ext_irq_input_1_edge_sel)
      2'h0: ext_irq_input_1_event = ~ext_irq_input_1_q & ext_irq_input_1;
      2'h1: ext_irq_input_1_event = ext_irq_input_1_q & ~ext_irq_input_1;
      default: ext_irq_input_1_event = ext_irq_input_1_q ^ ext_irq_input_1;
    endcase
    if (!ext_irq_input_1_seen_q) begin
      ext_irq_input_1_event = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: hw/pic_pkg.sv
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_IDLE,
    PIC_CYC1,
    PIC_CYC2,
    PIC_CYC3
  } pic_state_type;
endpackage

// File: hw/pic_prio.sv
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.svh"
module pic_prio (
  input wire logic [8:0] pending,
  output logic any,
  output logic [13:0] vector
);
  always_comb begin
    any = |pending;
    if (pending[`PIC_SRC_WU]) begin
      vector = `PIC_VEC_WU;
    end else if (pending[`PIC_SRC_EXT_IRQ_INPUT_0]) begin
      vector = `PIC_VEC_EXT_IRQ_INPUT_0;
    end else if (pending[`PIC_SRC_EXT_IRQ_INPUT_1]) begin
      vector = `PIC_VEC_EXT_IRQ_INPUT_1;
    end else if (pending[`PIC_SRC_TA]) begin
      vector = `PIC_VEC_TA;
    end else if (pending[`PIC_SRC_TB] | pending[`PIC_SRC_TD]) begin
      vector = `PIC_VEC_TBD;
    end else if (pending[`PIC_SRC_TC]) begin
      vector = `PIC_VEC_TC;
    end else begin
      vector = `PIC_VEC_SAD;
    end
  end
endmodule
`default_nettype wire

// File: hw/pic_regs.svh
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// Register byte addresses on the APB slave.
`define PIC_ADDR_IRQ 12'h000
`define PIC_ADDR_CTRL 12'h004
`define PIC_ADDR_MASK 12'h008
`define PIC_ADDR_FLAG 12'h00C
`define PIC_ADDR_STAT 12'h010
`define PIC_ADDR_SP 12'h014
`define PIC_ADDR_PC 12'h018

// Field positions in the irq register.
`define PIC_IRQ_IE_BIT 0
`define PIC_IRQ_WUF_BIT 2
`define PIC_IRQ_WUM_BIT 3

// Field positions in the ctrl register.
`define PIC_CTRL_STOP_BIT 0

// Flag and mask bit order for the nine sources.
`define PIC_NSRC 9
`define PIC_SRC_WU 0
`define PIC_SRC_EXT_IRQ_INPUT_0 1
`define PIC_SRC_EXT_IRQ_INPUT_1 2
`define PIC_SRC_TA 3
`define PIC_SRC_TB 4
`define PIC_SRC_TD 5
`define PIC_SRC_TC 6
`define PIC_SRC_SER 7
`define PIC_SRC_AD 8

// Reset values, with the stack pointer step and fixed top bits.
`define PIC_MASK_RST 9'h1FF
`define PIC_FLAG_RST 9'h000
`define PIC_SP_RST 10'h3FF
`define PIC_SP_STEP 10'h004
`define PIC_SP_TOP 4'hF
`define PIC_PC_RST 14'h0000
`define PIC_ST_RST 1'h1

// Vector addresses.
`define PIC_VEC_WU 14'h0002
`define PIC_VEC_EXT_IRQ_INPUT_0 14'h0004
`define PIC_VEC_EXT_IRQ_INPUT_1 14'h0006
`define PIC_VEC_TA 14'h0008
`define PIC_VEC_TBD 14'h000A
`define PIC_VEC_TC 14'h000C
`define PIC_VEC_SAD 14'h000E

`endif

// File: test/pic_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module pic_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic irq_hold_fetch,
  input wire logic stack_push,
  input wire logic [15:0] stack_wdata,
  input wire logic pc_load,
  input wire logic [13:0] pc_load_value,
  input wire logic return_from_irq_instr,
  output logic instr_boundary,
  output logic carry_flag,
  output logic branch_status_flag,
  output logic [13:0] cpu_pc,
  output logic [15:0] stack_rdata
);
  logic [1:0] phase_q;
  logic [15:0] saved_q;
  // Slow mode stretches instructions to three cycles, so acceptance must wait for the end.
  assign instr_boundary = !irq_hold_fetch && (!slow || phase_q == 2'h2);
  assign carry_flag = cpu_pc[0];
  assign branch_status_flag = cpu_pc[1];
  // The popped word is only valid during a return, so the inverse is shown otherwise.
  assign stack_rdata = return_from_irq_instr ? saved_q : ~saved_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= 2'h0;
    end else if (irq_hold_fetch || phase_q == 2'h2) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_pc <= 14'h0000;
    end else if (pc_load) begin
      cpu_pc <= pc_load_value;
    end else if (instr_boundary) begin
      cpu_pc <= cpu_pc + 14'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      saved_q <= 16'h0000;
    end else if (stack_push) begin
      saved_q <= stack_wdata;
    end
  end
endmodule
`default_nettype wire

// File: test/pic_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic instr_boundary,
  input wire logic return_from_irq_instr,
  input wire logic subroutine_return_instr,
  input wire logic carry_flag,
  input wire logic branch_status_flag,
  input wire logic [13:0] cpu_pc,
  input wire logic [15:0] stack_rdata,
  input wire logic irq_take,
  input wire logic irq_hold_fetch,
  input wire logic stack_push,
  input wire logic [9:0] stack_addr,
  input wire logic [15:0] stack_wdata,
  input wire logic pc_load,
  input wire logic flags_restore,
  input wire logic carry_restore,
  input wire logic status_restore,
  input wire logic global_irq_enable
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_TAKE_GATED: assert property (
    irq_take |-> global_irq_enable && instr_boundary && !irq_hold_fetch)
    else $error("Take while disabled or mid-instruction.");
  AST_HOLD_THREE: assert property (
    irq_take |=> irq_hold_fetch[*3])
    else $error("Fetch not held for the handling cycles.");
  AST_IE_CLEARED: assert property (
    irq_take |-> ##2 !global_irq_enable)
    else $error("Enable not cleared in second cycle.");
  AST_PUSH_CYCLES: assert property (
    irq_take |-> ##1 !stack_push ##1 stack_push[*2])
    else $error("Push not in cycles two and three.");
  AST_PUSH_DATA: assert property (
    irq_take |-> ##2 stack_wdata == $past({carry_flag, branch_status_flag, cpu_pc}))
    else $error("Pushed word wrong.");
  AST_PC_LOAD: assert property (
    irq_take |-> !pc_load ##1 !pc_load ##1 !pc_load ##1 pc_load)
    else $error("Vector load not in cycle three.");
  AST_SP_DEC: assert property (
    irq_take |-> ##3 stack_addr == $past(stack_addr) - 10'h004)
    else $error("Stack pointer not lowered by four.");
  AST_RETI_IE: assert property (
    return_from_irq_instr && !irq_hold_fetch && !irq_take |=> global_irq_enable)
    else $error("Return did not set enable.");
  AST_RETI_FLAGS: assert property (
    return_from_irq_instr |=> flags_restore && carry_restore == $past(stack_rdata[15])
      && status_restore == $past(stack_rdata[14]))
    else $error("Flags not restored.");
  AST_RTN_KEEPS: assert property (
    subroutine_return_instr && !return_from_irq_instr |=> !flags_restore)
    else $error("Plain return restored flags.");
endmodule
bind pic_ctrl pic_ctrl_monitor pic_ctrl_monitor_i (.pclk(pclk), .presetn(presetn),
  .instr_boundary(instr_boundary), .return_from_irq_instr(return_from_irq_instr),
  .subroutine_return_instr(subroutine_return_instr), .carry_flag(carry_flag),
  .branch_status_flag(branch_status_flag), .cpu_pc(cpu_pc), .stack_rdata(stack_rdata),
  .irq_take(irq_take), .irq_hold_fetch(irq_hold_fetch), .stack_push(stack_push),
  .stack_addr(stack_addr), .stack_wdata(stack_wdata), .pc_load(pc_load),
  .flags_restore(flags_restore), .carry_restore(carry_restore),
  .status_restore(status_restore), .global_irq_enable(global_irq_enable));
`default_nettype wire

// File: test/prioritized_interrupt_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pic_regs.svh"
module prioritized_interrupt_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perr, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq_take, irq_hold_fetch, stack_push, pc_load, instr_boundary;
  logic flags_restore, carry_restore, status_restore, global_irq_enable, carry_flag;
  logic branch_status_flag, return_from_irq_instr = 1'b0, subroutine_return_instr = 1'b0;
  logic [3:0] wakeup_in_n = 4'hF;
  logic ext_irq_input_0 = 1'b1, ext_irq_input_1 = 1'b0;
  logic [1:0] ext_irq_input_1_edge_sel = 2'h0;
  logic [5:0] ev = 6'h00;
  logic [13:0] cpu_pc, pc_load_value;
  logic [15:0] stack_wdata, stack_rdata;
  logic [9:0] stack_addr;
  logic [8:0] flg = 9'h1FF;
  logic [13:0] vec [0:8] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000A, 14'h000A,
    14'h000C, 14'h000E, 14'h000E};
  int fail_count = 0, comparisons = 0;
  logic [31:0] take_count = 32'h0;
  logic [13:0] vec_seen = 14'h0000;
  always #20 pclk = ~pclk;
  pic_ctrl pic_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wakeup_in_n, .ext_irq_input_0, .ext_irq_input_1, .ext_irq_input_1_edge_sel,
    .timer_a_ovf(ev[0]), .timer_b_ovf(ev[1]), .timer_c_ovf(ev[2]), .timer_d_event(ev[3]),
    .serial_done(ev[4]), .adc_done(ev[5]), .instr_boundary, .return_from_irq_instr,
    .subroutine_return_instr, .carry_flag, .branch_status_flag, .cpu_pc, .irq_take,
    .irq_hold_fetch, .stack_push, .stack_addr, .stack_wdata, .pc_load, .pc_load_value,
    .stack_rdata, .flags_restore, .carry_restore, .status_restore, .global_irq_enable);
  pic_cpu_model pic_cpu_model_i (.pclk, .presetn, .slow, .irq_hold_fetch, .stack_push,
    .stack_wdata, .pc_load, .pc_load_value, .return_from_irq_instr, .instr_boundary,
    .carry_flag, .branch_status_flag, .cpu_pc, .stack_rdata);
  // The take strobe lasts one cycle, so it is counted at the edge rather than polled.
  always @(posedge pclk) begin
    if (irq_take === 1'b1) begin
      take_count <= take_count + 32'h1;
    end
    if (pc_load === 1'b1) begin
      vec_seen <= pc_load_value;
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(r, exp);
  endtask
  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`PIC_ADDR_MASK, 32'h000001FF);
    rd_chk(`PIC_ADDR_FLAG, 32'h00000000);
    rd_chk(`PIC_ADDR_IRQ, 32'h00000008);
    rd_chk(`PIC_ADDR_SP, 32'h000003FF);
    rd_chk(12'h01C, 32'h00000000);
    check({31'h0, perr}, 32'h00000001);
    apb(1'b1, `PIC_ADDR_FLAG, 32'h000001FF);
    rd_chk(`PIC_ADDR_FLAG, 32'h00000000);
    apb(1'b1, `PIC_ADDR_CTRL, 32'h00000001);
    wakeup_in_n <= 4'hE;
    repeat (3) @(posedge pclk);
    rd_chk(`PIC_ADDR_IRQ, 32'h00000008);
    wakeup_in_n <= 4'hF;
    apb(1'b1, `PIC_ADDR_CTRL, 32'h00000000);
    wakeup_in_n <= 4'hB;
    ext_irq_input_0 <= 1'b0;
    ext_irq_input_1 <= 1'b1;
    ev <= 6'h3F;
    @(posedge pclk);
    ev <= 6'h00;
    @(posedge pclk);
    rd_chk(`PIC_ADDR_FLAG, 32'h000001FF);
    rd_chk(`PIC_ADDR_STAT, 32'h00000000);
    apb(1'b1, `PIC_ADDR_FLAG, 32'h000001FF);
    rd_chk(`PIC_ADDR_FLAG, 32'h000001FF);
    apb(1'b1, `PIC_ADDR_MASK, 32'h00000000);
    rd_chk(`PIC_ADDR_STAT, 32'h000001FF);
    slow <= 1'b1;
    apb(1'b1, `PIC_ADDR_IRQ, 32'h00000005);
    for (int i = 0; i < 9; i++) begin
      for (int n = 0; n < 100 && take_count != i + 1; n++) begin
        @(negedge pclk);
      end
      check(take_count, i + 1);
      @(posedge pclk);
      rd_chk(`PIC_ADDR_FLAG, {23'h0, flg});
      rd_chk(`PIC_ADDR_IRQ, {29'h0, flg[0], 2'h0});
      rd_chk(`PIC_ADDR_PC, {18'h0, vec[i]});
      rd_chk(`PIC_ADDR_SP, 32'h000003FB);
      check({18'h0, vec_seen}, {18'h0, vec[i]});
      flg[i] = 1'b0;
      apb(1'b1, `PIC_ADDR_FLAG, {23'h0, ~(9'h001 << i)});
      return_from_irq_instr <= 1'b1;
      @(posedge pclk);
      return_from_irq_instr <= 1'b0;
      @(posedge pclk);
    end
    rd_chk(`PIC_ADDR_IRQ, 32'h00000001);
    rd_chk(`PIC_ADDR_SP, 32'h000003FF);
    rd_chk(`PIC_ADDR_STAT, 32'h00000000);
    subroutine_return_instr <= 1'b1;
    @(posedge pclk);
    subroutine_return_instr <= 1'b0;
    repeat (2) @(posedge pclk);
    rd_chk(`PIC_ADDR_SP, 32'h000003C3);
    apb(1'b1, `PIC_ADDR_MASK, 32'h00000004);
    ext_irq_input_1_edge_sel <= 2'h1;
    ext_irq_input_1 <= 1'b0;
    repeat (2) @(posedge pclk);
    rd_chk(`PIC_ADDR_FLAG, 32'h00000004);
    apb(1'b1, `PIC_ADDR_FLAG, 32'h000001FB);
    ext_irq_input_1_edge_sel <= 2'h2;
    ext_irq_input_1 <= 1'b1;
    repeat (2) @(posedge pclk);
    rd_chk(`PIC_ADDR_FLAG, 32'h00000004);
    check(take_count, 32'h00000009);
    stop_test();
  end
  initial begin
    #(40 * 4000);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
